/* File: include/iep_pkg.sv */
package iep_pkg;

  // ---------------------------------------------------------------
  // Register map (word offsets of the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_ENABLE_GROUP2 = 4'h0;
  localparam logic [3:0] ADDR_PRIORITY_GROUP0 = 4'h1;
  localparam logic [3:0] ADDR_PRIORITY_GROUP1 = 4'h2;
  localparam logic [3:0] ADDR_FLAG_STATUS = 4'h3;
  localparam logic [3:0] ADDR_EVENT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENT_MASK = 4'h5;
  localparam logic [3:0] ADDR_WINNER = 4'h6;

  // ---------------------------------------------------------------
  // Source numbering
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 14;
  localparam logic [3:0] SRC_PARALLEL = 4'h0;
  localparam logic [3:0] SRC_COMPARE5 = 4'h1;
  localparam logic [3:0] SRC_CAPTURE5 = 4'h2;
  localparam logic [3:0] SRC_CAPTURE4 = 4'h3;
  localparam logic [3:0] SRC_CAPTURE3 = 4'h4;
  localparam logic [3:0] SRC_SERIAL2_EVENT = 4'h5;
  localparam logic [3:0] SRC_SERIAL2_FAULT = 4'h6;
  localparam logic [3:0] SRC_TIMER1 = 4'h7;
  localparam logic [3:0] SRC_COMPARE1 = 4'h8;
  localparam logic [3:0] SRC_CAPTURE1 = 4'h9;
  localparam logic [3:0] SRC_EXT0 = 4'ha;
  localparam logic [3:0] SRC_TIMER2 = 4'hb;
  localparam logic [3:0] SRC_COMPARE2 = 4'hc;
  localparam logic [3:0] SRC_CAPTURE2 = 4'hd;

  // ---------------------------------------------------------------
  // Enable register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_PARALLEL_EN = 13;
  localparam int BIT_COMPARE5_EN = 9;
  localparam int BIT_CAPTURE5_EN = 7;
  localparam int BIT_CAPTURE4_EN = 6;
  localparam int BIT_CAPTURE3_EN = 5;
  localparam int BIT_SERIAL2_EVENT_EN = 1;
  localparam int BIT_SERIAL2_FAULT_EN = 0;
  localparam logic [15:0] ENABLE_GROUP2_MASK = 16'h22e3;
  localparam logic [15:0] ENABLE_GROUP2_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Priority register field positions (low bit of each field)
  // ---------------------------------------------------------------
  localparam int PRIO_W = 3;
  localparam int FLD_HI = 12;
  localparam int FLD_MID = 8;
  localparam int FLD_LO = 4;
  localparam int FLD_LOW0 = 0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_CEILING = 3'h7;
  localparam logic [15:0] PRIORITY_GROUP0_MASK = 16'h7777;
  localparam logic [15:0] PRIORITY_GROUP0_RESET = 16'h4444;
  localparam logic [15:0] PRIORITY_GROUP1_MASK = 16'h7770;
  localparam logic [15:0] PRIORITY_GROUP1_RESET = 16'h4440;

  // ---------------------------------------------------------------
  // Event status bits
  // ---------------------------------------------------------------
  localparam int EVT_W = 2;
  localparam int EVT_REQ_RISE = 0;
  localparam int EVT_WINNER_CHANGE = 1;

  // Core side request bundle
  typedef struct packed {
    logic valid;
    logic [3:0] source;
    logic [PRIO_W-1:0] level;
  } iep_request_t;

  // Register port bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } iep_bus_t;

endpackage

/* File: verilog/iep_rank.sv */
`timescale 1ns/100ps
module iep_rank
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Per-source inputs and core state
  input wire logic [NUM_SRC-1:0] live_i,
  input wire logic [NUM_SRC*PRIO_W-1:0] prio_i,
  input wire logic [PRIO_W-1:0] cpu_priority_level_i,
  input wire logic cpu_level_high_i,
  // Registered winner
  output iep_request_t req_o
);

  // ---------------------------------------------------------------
  // Priority search
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] eligible;
  iep_request_t next_req;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_elig
      // Code zero never beats the core; ceiling level masks all
      assign eligible[g] = live_i[g] && !cpu_level_high_i
        && (prio_i[g*PRIO_W +: PRIO_W] != PRIO_OFF)
        && (prio_i[g*PRIO_W +: PRIO_W] > cpu_priority_level_i);
    end
  endgenerate

  // Lowest source number wins a tie
  always_comb
  begin
    next_req = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i] && (!next_req.valid || prio_i[i*PRIO_W +: PRIO_W] >= next_req.level))
      begin
        next_req.valid = 1'b1;
        next_req.source = 4'(i);
        next_req.level = prio_i[i*PRIO_W +: PRIO_W];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      req_o <= '0;
    else
      req_o <= next_req;
  end

endmodule // iep_rank

/* File: verilog/iep_top.sv */
// How it works
// - One enable bit for each of the seven group2 sources; one passes the request, zero blocks it.
// - Enable register: parallel 13, compare5 9, capture5..3 7..5, serial2 event 1, fault 0.
// - Three-bit priority: 7 highest down to 1; code 0 disables the source.
// - Priority group0: timer1 14:12, compare1 10:8, capture1 6:4, ext0 2:0.
// - Reset loads priority 4 in every field and clears every enable.
// - Unimplemented bits read zero and ignore writes.
// - Core level 7 or above blocks every user source.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module iep_top
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Peripheral flags, same clock domain
  input wire logic [NUM_SRC-1:0] flag_i,
  // Core state
  input wire logic [PRIO_W-1:0] cpu_priority_level_i,
  input wire logic cpu_level_high_i,
  // Request toward the core
  output logic core_req_o,
  output logic [3:0] core_src_o,
  output logic [PRIO_W-1:0] core_level_o,
  // Event interrupt
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [15:0] interrupt_enable_group2;
  logic [15:0] interrupt_priority_group0;
  logic [15:0] interrupt_priority_group1;
  logic [EVT_W-1:0] event_status;
  logic [EVT_W-1:0] event_mask;
  iep_bus_t bus;
  iep_request_t req;
  iep_request_t req_q;

  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  wire wr_enable = bus.wr && (bus.addr == ADDR_ENABLE_GROUP2);
  wire wr_prio0 = bus.wr && (bus.addr == ADDR_PRIORITY_GROUP0);
  wire wr_prio1 = bus.wr && (bus.addr == ADDR_PRIORITY_GROUP1);
  wire wr_status = bus.wr && (bus.addr == ADDR_EVENT_STATUS);
  wire wr_mask = bus.wr && (bus.addr == ADDR_EVENT_MASK);

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      interrupt_enable_group2 <= ENABLE_GROUP2_RESET;
      interrupt_priority_group0 <= PRIORITY_GROUP0_RESET;
      interrupt_priority_group1 <= PRIORITY_GROUP1_RESET;
      event_mask <= '0;
    end
    else
    begin
      if (wr_enable)
        interrupt_enable_group2 <= bus.wdata & ENABLE_GROUP2_MASK;
      if (wr_prio0)
        interrupt_priority_group0 <= bus.wdata & PRIORITY_GROUP0_MASK;
      if (wr_prio1)
        interrupt_priority_group1 <= bus.wdata & PRIORITY_GROUP1_MASK;
      if (wr_mask)
        event_mask <= bus.wdata[EVT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Per-source enable and priority
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC*PRIO_W-1:0] src_prio;
  logic [NUM_SRC-1:0] live;

  // Sources with no enable bit in this block pass always
  assign src_en[SRC_PARALLEL] = interrupt_enable_group2[BIT_PARALLEL_EN];
  assign src_en[SRC_COMPARE5] = interrupt_enable_group2[BIT_COMPARE5_EN];
  assign src_en[SRC_CAPTURE5] = interrupt_enable_group2[BIT_CAPTURE5_EN];
  assign src_en[SRC_CAPTURE4] = interrupt_enable_group2[BIT_CAPTURE4_EN];
  assign src_en[SRC_CAPTURE3] = interrupt_enable_group2[BIT_CAPTURE3_EN];
  assign src_en[SRC_SERIAL2_EVENT] = interrupt_enable_group2[BIT_SERIAL2_EVENT_EN];
  assign src_en[SRC_SERIAL2_FAULT] = interrupt_enable_group2[BIT_SERIAL2_FAULT_EN];
  assign src_en[NUM_SRC-1:SRC_TIMER1] = '1;

  // Group2 sources share a priority parameter of this block
  assign src_prio[SRC_TIMER1*PRIO_W +: PRIO_W] = interrupt_priority_group0[FLD_HI +: PRIO_W];
  assign src_prio[SRC_COMPARE1*PRIO_W +: PRIO_W] = interrupt_priority_group0[FLD_MID +: PRIO_W];
  assign src_prio[SRC_CAPTURE1*PRIO_W +: PRIO_W] = interrupt_priority_group0[FLD_LO +: PRIO_W];
  assign src_prio[SRC_EXT0*PRIO_W +: PRIO_W] = interrupt_priority_group0[FLD_LOW0 +: PRIO_W];
  assign src_prio[SRC_TIMER2*PRIO_W +: PRIO_W] = interrupt_priority_group1[FLD_HI +: PRIO_W];
  assign src_prio[SRC_COMPARE2*PRIO_W +: PRIO_W] = interrupt_priority_group1[FLD_MID +: PRIO_W];
  assign src_prio[SRC_CAPTURE2*PRIO_W +: PRIO_W] = interrupt_priority_group1[FLD_LO +: PRIO_W];

  genvar g;
  generate
    for (g = 0; g < SRC_TIMER1; g++)
    begin : g_fixed_prio
      assign src_prio[g*PRIO_W +: PRIO_W] = PRIO_RESET;
    end
    for (g = 0; g < NUM_SRC; g++)
    begin : g_live
      assign live[g] = flag_i[g] & src_en[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Ranking
  // ---------------------------------------------------------------
  iep_rank u_rank
  (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .live_i(live),
    .prio_i(src_prio),
    .cpu_priority_level_i(cpu_priority_level_i),
    .cpu_level_high_i(cpu_level_high_i),
    .req_o(req)
  );

  assign core_req_o = req.valid;
  assign core_src_o = req.source;
  assign core_level_o = req.level;

  // ---------------------------------------------------------------
  // Event status, set wins over clear
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] next_event_status;

  assign evt_set[EVT_REQ_RISE] = req.valid && !req_q.valid;
  assign evt_set[EVT_WINNER_CHANGE] = req.valid && req_q.valid && (req.source != req_q.source);
  assign next_event_status = (event_status & ~(wr_status ? bus.wdata[EVT_W-1:0] : '0)) | evt_set;

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      req_q <= '0;
      event_status <= '0;
    end
    else
    begin
      req_q <= req;
      event_status <= next_event_status;
    end
  end

  assign irq_o = |(event_status & event_mask);

  // ---------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ---------------------------------------------------------------
  logic [15:0] read_mux;
  logic [15:0] flag_view;

  assign flag_view = {2'h0, flag_i};

  always_comb
  begin
    case (bus.addr)
      ADDR_ENABLE_GROUP2: read_mux = interrupt_enable_group2;
      ADDR_PRIORITY_GROUP0: read_mux = interrupt_priority_group0;
      ADDR_PRIORITY_GROUP1: read_mux = interrupt_priority_group1;
      ADDR_FLAG_STATUS: read_mux = flag_view;
      ADDR_EVENT_STATUS: read_mux = {14'h0, event_status};
      ADDR_EVENT_MASK: read_mux = {14'h0, event_mask};
      ADDR_WINNER: read_mux = {8'h0, req.valid, req.source, req.level};
      default: read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 16'h0000;
    else if (bus.rd)
      rdata_o <= read_mux;
    else
      rdata_o <= 16'h0000;
  end

endmodule // iep_top

/* File: tb/iep_top_props.sv */
`timescale 1ns/100ps
module iep_top_props
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Sources and core
  input wire logic [NUM_SRC-1:0] flag_i,
  input wire logic [PRIO_W-1:0] cpu_priority_level_i,
  input wire logic cpu_level_high_i,
  input wire logic core_req_o,
  input wire logic [3:0] core_src_o,
  input wire logic [PRIO_W-1:0] core_level_o,
  input wire logic irq_o
);
  logic [NUM_SRC-1:0] flag_q;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // Flags as the winner logic saw them
  always_ff @(posedge clk_sys_i or posedge reset_i)
    if (reset_i)
      flag_q <= '0;
    else
      flag_q <= flag_i;
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (rd_i && addr_i > ADDR_WINNER |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_GRP1_LOW: assert property (rd_i && addr_i == ADDR_PRIORITY_GROUP1 |=> rdata_o[3:0] == 4'h0)
    else $error("priority group1 low nibble set");
  AST_HIGH_BLOCK: assert property (cpu_level_high_i |=> !core_req_o)
    else $error("request while core level high");
  AST_CEILING: assert property (cpu_priority_level_i == PRIO_CEILING |=> !core_req_o)
    else $error("request at core level 7");
  AST_STRICT: assert property (core_req_o |-> core_level_o > $past(cpu_priority_level_i))
    else $error("request not above core level");
  AST_FLAGGED: assert property (core_req_o |-> flag_q[core_src_o])
    else $error("request from idle source");
  AST_FIXED_PRIO: assert property (core_req_o && core_src_o < SRC_TIMER1 |-> core_level_o == PRIO_RESET)
    else $error("fixed source priority wrong");
endmodule // iep_top_props
bind iep_top iep_top_props u_iep_top_props (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .flag_i, .cpu_priority_level_i, .cpu_level_high_i, .core_req_o, .core_src_o, .core_level_o, .irq_o);

/* File: tb/iep_partner.sv */
`timescale 1ns/100ps
module iep_partner
  import iep_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Commands from the bench
  input wire logic [NUM_SRC-1:0] raise_i,
  input wire logic [3:0] level_i,
  // Toward the design
  output logic [NUM_SRC-1:0] flag_o = '0,
  output logic [PRIO_W-1:0] cpu_priority_level_o = '0,
  output logic cpu_level_high_o = 1'b0
);
  // Peripherals and core show new state one edge after the command
  always @(posedge clk_sys_i)
  begin
    flag_o <= raise_i;
    cpu_priority_level_o <= level_i[2:0];
    cpu_level_high_o <= level_i[3];
  end
endmodule // iep_partner

/* File: tb/tb_iep_top.sv */
`timescale 1ns/100ps
module tb_iep_top
  import iep_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [NUM_SRC-1:0] raise = '0;
  logic [3:0] lvl = 4'h0;
  logic [15:0] rdata_o;
  logic [NUM_SRC-1:0] flag;
  logic [PRIO_W-1:0] cpl;
  logic high;
  logic core_req_o;
  logic [3:0] core_src_o;
  logic [PRIO_W-1:0] core_level_o;
  logic irq_o;
  logic [15:0] rnd = 16'h8592;
  int num_errors = 0;
  int checked = 0;
  int m_en = 0;
  int m_p0 = 0;
  int m_p1 = 0;
  int ebit[7] = '{13, 9, 7, 6, 5, 1, 0};
  initial forever #10 clk_sys_i = ~clk_sys_i;
  iep_partner u_iep_partner (.clk_sys_i, .raise_i(raise), .level_i(lvl), .flag_o(flag),
    .cpu_priority_level_o(cpl), .cpu_level_high_o(high));
  iep_top u_iep_top (.clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .flag_i(flag),
    .cpu_priority_level_i(cpl), .cpu_level_high_i(high), .core_req_o, .core_src_o, .core_level_o, .irq_o);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected winner {valid, source, level}
  function automatic logic [15:0] want();
    int best;
    int src;
    int p;
    int e;
    best = 0;
    src = 0;
    for (int s = 0; s < 14; s++)
    begin
      p = s < 7 ? 4 : ((s < 11 ? m_p0 >> (12 - 4 * (s - 7)) : m_p1 >> (12 - 4 * (s - 11))) & 7);
      e = s < 7 ? (m_en >> ebit[s]) & 1 : 1;
      if (raise[s] && e == 1 && p > lvl[2:0] && !lvl[3] && p > best)
      begin
        best = p;
        src = s;
      end
    end
    return best != 0 ? {8'h01, src[3:0], best[2:0]} >> 0 : 16'h0000;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_req();
    #1 chk("request", want(), {8'h00, core_req_o, core_req_o ? {core_src_o, core_level_o} : 7'h00});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk("rdata", exp, rdata_o);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdchk(ADDR_ENABLE_GROUP2, 16'h0000);
    rdchk(ADDR_PRIORITY_GROUP0, 16'h4444);
    rdchk(ADDR_PRIORITY_GROUP1, 16'h4440);
    wr(ADDR_ENABLE_GROUP2, 16'hffff);
    wr(ADDR_PRIORITY_GROUP0, 16'hffff);
    wr(ADDR_PRIORITY_GROUP1, 16'hffff);
    wr(4'h9, 16'hffff);
    rdchk(ADDR_ENABLE_GROUP2, 16'h22e3);
    rdchk(ADDR_PRIORITY_GROUP0, 16'h7777);
    rdchk(ADDR_PRIORITY_GROUP1, 16'h7770);
    rdchk(4'h9, 16'h0000);
    // Random enables, priorities, flags and core level
    for (int i = 0; i < 60; i++)
    begin
      rnd = lfsr(rnd);
      wr(ADDR_ENABLE_GROUP2, rnd);
      m_en = rnd & 16'h22e3;
      rnd = lfsr(rnd);
      wr(ADDR_PRIORITY_GROUP0, rnd);
      m_p0 = rnd & 16'h7777;
      rnd = lfsr(rnd);
      wr(ADDR_PRIORITY_GROUP1, rnd);
      m_p1 = rnd & 16'h7770;
      rdchk(ADDR_PRIORITY_GROUP1, m_p1[15:0]);
      rnd = lfsr(rnd);
      raise <= rnd[13:0];
      lvl <= {rnd[15] & rnd[14], rnd[11:9]};
      repeat (3) @(posedge clk_sys_i);
      chk_req();
    end
    // Event interrupt raise, mask and clear
    @(posedge clk_sys_i);
    raise <= '0;
    lvl <= 4'h0;
    wr(ADDR_PRIORITY_GROUP0, 16'h4444);
    m_p0 = 16'h4444;
    wr(ADDR_EVENT_STATUS, 16'h0003);
    wr(ADDR_EVENT_MASK, 16'h0001);
    #1 chk("irq", 16'h0000, {15'h0000, irq_o});
    @(posedge clk_sys_i);
    raise <= 14'h0080;
    for (int n = 0; n < 8 && irq_o !== 1'b1; n++)
      @(posedge clk_sys_i);
    #1 chk("irq", 16'h0001, {15'h0000, irq_o});
    chk_req();
    rdchk(ADDR_WINNER, 16'h00bc);
    rdchk(ADDR_FLAG_STATUS, 16'h0080);
    wr(ADDR_EVENT_MASK, 16'h0000);
    @(posedge clk_sys_i);
    #1 chk("irq", 16'h0000, {15'h0000, irq_o});
    wr(ADDR_EVENT_STATUS, 16'h0003);
    wr(ADDR_EVENT_MASK, 16'h0001);
    @(posedge clk_sys_i);
    #1 chk("irq", 16'h0000, {15'h0000, irq_o});
    rdchk(ADDR_EVENT_STATUS, 16'h0000);
    rdchk(ADDR_EVENT_MASK, 16'h0001);
    report_and_stop();
  end
endmodule // tb_iep_top
